// *** rtl/slm_defines.vh ***
`ifndef SLM_DEFINES_VH
`define SLM_DEFINES_VH

// link mode codes handled by the mapper
`define SLM_MODE_W        4
`define SLM_MODE0         4'h0
`define SLM_MODE1         4'h1
`define SLM_MODE2         4'h2
`define SLM_MODE3         4'h3

// sample and frame geometry
`define SLM_RES           9
`define SLM_SPC           10
`define SLM_CH_W          90
`define SLM_FRAME_W       80
`define SLM_MAX_LANES     8
`define SLM_LID_W         3

// slot geometry inside a lane frame
`define SLM_SLOT12        12
`define SLM_SLOT10        10
`define SLM_PAD3          3'h0
`define SLM_PAD1          1'h0
`define SLM_ZERO_OCTET    8'h00

// octets per lane frame for each mode
`define SLM_OCT_W         4
`define SLM_OCT_MODE0     4'h8
`define SLM_OCT_MODE1     4'h2
`define SLM_OCT_MODE2     4'h1
`define SLM_OCT_MODE3     4'h5

// reset values
`define SLM_MODE_RST      4'h0
`define SLM_FRAME_RST     80'h0

`endif

// *** rtl/slm_lane_reg.v ***
`timescale 1ns/1ps
`include "slm_defines.vh"

// one lane's frame holder: loads a whole frame at once, clears when powered down
module slm_lane_reg #(
    parameter W = `SLM_FRAME_W
) (
    input  wire         sys_clk,
    input  wire         rst,
    input  wire         load,      // frame strobe shared by all lanes
    input  wire         lane_on,   // lane used by the current mode
    input  wire [W-1:0] next_frame,
    output reg  [W-1:0] frame,     // bit W-1 leaves the lane first
    output reg          powered    // high while the lane is in use
);

    // frame register; a powered-down lane idles at all zero
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            frame   <= {W{1'b0}};
            powered <= 1'b0;
        end else begin
            powered <= lane_on;
            if (!lane_on) begin
                frame <= {W{1'b0}};
            end else if (load) begin
                frame <= next_frame;
            end
        end
    end

endmodule // slm_lane_reg

// *** rtl/slm_sample_mapper.v ***
`timescale 1ns/1ps
`include "slm_defines.vh"

// Behaviour
// RULE1: eight lanes multi-channel, four lanes single-channel
// RULE2: lowest lanes used, higher lanes powered down
// RULE3: lane id equals index, carries device id
// RULE4: all tail bits driven zero
// RULE5: samples placed most significant bit first
// RULE6: container bits beyond resolution are zero
// RULE7: no programmable multiframe length in 64B/66B
// RULE8: equal M and L sends samples time-ordered
// RULE9: mode 0 five 12-bit slots, tail nibble
// RULE10: mode 0 lane pairs carry channels A-D
// RULE11: mode 1 splits samples across lane octets
// RULE12: mode 1 single variant sends zero octet
// RULE13: mode 2 one 8-bit sample per lane
// RULE14: mode 3 four 10-bit slots per lane
// RULE15: all active lanes start frames together
// RULE16: layout chosen only from mode while inactive
module slm_sample_mapper #(
    parameter NUM_CH = 4,   // converter channels of this variant: 1, 2 or 4
    parameter DID_W  = 8    // width of the device identifier
) (
    input  wire                                 sys_clk,
    input  wire                                 rst,
    input  wire                                 link_active,
    input  wire [`SLM_MODE_W-1:0]               link_mode_select,
    input  wire [DID_W-1:0]                     device_identifier,
    input  wire                                 sample_valid,
    input  wire [`SLM_CH_W-1:0]                 samp_a,
    input  wire [`SLM_CH_W-1:0]                 samp_b,
    input  wire [`SLM_CH_W-1:0]                 samp_c,
    input  wire [`SLM_CH_W-1:0]                 samp_d,
    output wire [`SLM_MAX_LANES*`SLM_FRAME_W-1:0] lane_frames,
    output wire [`SLM_MAX_LANES-1:0]            lane_power_down,
    output wire [`SLM_MAX_LANES*`SLM_LID_W-1:0] lane_identifier,
    output reg  [DID_W-1:0]                     lane_device_id,
    output reg                                  frame_valid,
    output reg  [`SLM_OCT_W-1:0]                frame_octets,
    output reg                                  mode_supported
);

    // physical lanes of this variant
    localparam NUM_LANES = (NUM_CH == 1) ? 4 : 8; // see RULE1

    wire [4*`SLM_CH_W-1:0] all_s;                 // every channel's samples, A lowest
    reg  [`SLM_MODE_W-1:0] mode;                  // mode held while the link runs
    wire                   single;                // one-channel variant
    wire [3:0]             used;                  // lanes used by the held mode
    wire                   load;                  // frame strobe to every lane
    wire [`SLM_MAX_LANES-1:0] powered;            // lane holder status

    assign all_s  = {samp_d, samp_c, samp_b, samp_a};
    assign single = (NUM_CH == 1);

    // sample k of channel ch, 9 bits
    function [`SLM_RES-1:0] smp;
        input [4*`SLM_CH_W-1:0] s;
        input integer           ch;
        input integer           k;
        begin
            smp = s[ch*`SLM_CH_W + k*`SLM_RES +: `SLM_RES];
        end
    endfunction

    // lanes needed per mode and variant; unknown modes use none
    function [3:0] lanes_used;
        input [`SLM_MODE_W-1:0] m;
        input integer           nch;
        begin
            case (m)
                `SLM_MODE0: lanes_used = (nch == 1) ? 4'h2 : ((nch == 2) ? 4'h4 : 4'h8);
                `SLM_MODE1: lanes_used = (nch == 1) ? 4'h2 : ((nch == 2) ? 4'h3 : 4'h6);
                `SLM_MODE2: lanes_used = (nch == 1) ? 4'h1 : ((nch == 2) ? 4'h2 : 4'h4);
                `SLM_MODE3: lanes_used = (nch == 1) ? 4'h1 : ((nch == 2) ? 4'h2 : 4'h4);
                default:    lanes_used = 4'h0;
            endcase
        end
    endfunction

    // builds one lane's frame; unfilled bits stay zero and form the tail
    function [`SLM_FRAME_W-1:0] lane_frame;
        input [`SLM_MODE_W-1:0]  m;
        input integer            l;
        input                    one_ch;
        input [4*`SLM_CH_W-1:0]  s;
        integer                  k;
        integer                  ca;
        integer                  cb;
        reg   [`SLM_RES-1:0]     x0;
        reg   [`SLM_RES-1:0]     x1;
        reg   [7:0]              oct;
        begin
            lane_frame = `SLM_FRAME_RST; // see RULE4
            ca  = (l / 3) * 2;
            cb  = ca + 1;
            x0  = {`SLM_RES{1'b0}};
            x1  = {`SLM_RES{1'b0}};
            oct = `SLM_ZERO_OCTET;
            case (m)
                `SLM_MODE0: begin
                    // even samples on even lane, odd on odd lane of a pair
                    for (k = 0; k < 5; k = k + 1) begin // see RULE9
                        lane_frame[`SLM_FRAME_W-1-k*`SLM_SLOT12 -: `SLM_SLOT12] = // see RULE10
                            {smp(s, l / 2, 2*k + (l % 2)), `SLM_PAD3}; // see RULE8 see RULE6
                    end
                end
                `SLM_MODE1: begin
                    case (l % 3)
                        0: begin
                            x0 = smp(s, ca, 0);
                            x1 = smp(s, ca, 1);
                            lane_frame[`SLM_FRAME_W-1 -: 16] =
                                {x0, `SLM_PAD3, x1[8:5]}; // see RULE11
                        end
                        1: begin
                            x1  = smp(s, ca, 1);
                            x0  = smp(s, cb, 0);
                            oct = one_ch ? `SLM_ZERO_OCTET : x0[8:1]; // see RULE12
                            lane_frame[`SLM_FRAME_W-1 -: 16] =
                                {x1[4:0], `SLM_PAD3, oct}; // see RULE11
                        end
                        default: begin
                            x0 = smp(s, cb, 0);
                            x1 = smp(s, cb, 1);
                            lane_frame[`SLM_FRAME_W-1 -: 16] =
                                {x0[0], `SLM_PAD3, x1, `SLM_PAD3}; // see RULE11
                        end
                    endcase
                end
                `SLM_MODE2: begin
                    // 8-bit resolution keeps the upper sample bits
                    x0 = smp(s, l, 0);
                    lane_frame[`SLM_FRAME_W-1 -: 8] = x0[8:1]; // see RULE13
                end
                `SLM_MODE3: begin
                    for (k = 0; k < 4; k = k + 1) begin
                        lane_frame[`SLM_FRAME_W-1-k*`SLM_SLOT10 -: `SLM_SLOT10] =
                            {smp(s, l, k), `SLM_PAD1}; // see RULE14 see RULE6
                    end
                end
                default: begin
                    lane_frame = `SLM_FRAME_RST;
                end
            endcase
        end
    endfunction

    // mode and identifier are only taken while the link is down, so a running
    // link never sees its layout change mid-frame
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            mode           <= `SLM_MODE_RST;
            lane_device_id <= {DID_W{1'b0}};
        end else if (!link_active) begin
            mode           <= link_mode_select; // see RULE16
            lane_device_id <= device_identifier; // see RULE3
        end
    end

    // frame octet count and support flag; 64B/66B modes are not mapped and
    // take no multiframe length from outside
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            frame_octets   <= `SLM_OCT_MODE0;
            mode_supported <= 1'b1;
        end else begin
            mode_supported <= (used != 4'h0); // see RULE7
            case (mode)
                `SLM_MODE0: frame_octets <= `SLM_OCT_MODE0;
                `SLM_MODE1: frame_octets <= `SLM_OCT_MODE1;
                `SLM_MODE2: frame_octets <= `SLM_OCT_MODE2;
                `SLM_MODE3: frame_octets <= `SLM_OCT_MODE3;
                default:    frame_octets <= {`SLM_OCT_W{1'b0}};
            endcase
        end
    end

    assign used = lanes_used(mode, NUM_CH);
    // one strobe loads every used lane in the same cycle
    assign load = sample_valid & link_active & (used != 4'h0); // see RULE15

    // frame valid pulse follows the load by one cycle, with the frames
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            frame_valid <= 1'b0;
        end else begin
            frame_valid <= load;
        end
    end

    // one frame holder per lane of the widest variant; absent lanes of the small variant
    // are tied down so the port list is the same for every variant
    genvar g;
    generate
        for (g = 0; g < `SLM_MAX_LANES; g = g + 1) begin : g_lane
            // the index as a plain constant, so that its low bits can be taken
            localparam integer LANE_IDX = g;
            wire lane_on;
            assign lane_on = (g < NUM_LANES) && (g < used); // see RULE2 see RULE1
            slm_lane_reg #(
                .W (`SLM_FRAME_W)
            ) u_lane (
                .sys_clk    (sys_clk),
                .rst        (rst),
                .load       (load),
                .lane_on    (lane_on),
                .next_frame (lane_frame(mode, g, single, all_s)), // see RULE5
                .frame      (lane_frames[g*`SLM_FRAME_W +: `SLM_FRAME_W]),
                .powered    (powered[g])
            );
            assign lane_power_down[g] = ~powered[g]; // see RULE2
            assign lane_identifier[g*`SLM_LID_W +: `SLM_LID_W] = LANE_IDX[`SLM_LID_W-1:0]; // see RULE3
        end
    endgenerate

endmodule // slm_sample_mapper

// *** testbench/slm_sample_mapper_assertions.sv ***
`timescale 1ns/1ps
// watches the mapper from its ports only
module slm_chk #(
    parameter DID_W  = 8,
    parameter NUM_CH = 4    // channels of the watched variant: 1, 2 or 4
) (
    input wire             sys_clk,
    input wire             rst,
    input wire             link_active,
    input wire             sample_valid,
    input wire [639:0]     lane_frames,
    input wire [7:0]       lane_power_down,
    input wire [23:0]      lane_identifier,
    input wire [DID_W-1:0] lane_device_id,
    input wire             frame_valid,
    input wire [3:0]       frame_octets,
    input wire             mode_supported
);
    // power-down mask per frame size; the small variants use fewer low lanes
    localparam [7:0] PD_NINE  = (NUM_CH == 1) ? 8'hfc : ((NUM_CH == 2) ? 8'hf0 : 8'h00);
    localparam [7:0] PD_SPLIT = (NUM_CH == 1) ? 8'hfc : ((NUM_CH == 2) ? 8'hf8 : 8'hc0);
    localparam [7:0] PD_FOUR  = (NUM_CH == 1) ? 8'hfe : ((NUM_CH == 2) ? 8'hfc : 8'hf0);
    wire [7:0] pd_exp; // mask that the held frame size calls for
    assign pd_exp = (frame_octets == 4'h8) ? PD_NINE :
                    (frame_octets == 4'h2) ? PD_SPLIT :
                    (frame_octets == 4'h0) ? 8'hff : PD_FOUR;
    reg [1:0] age; // edges since reset, config outputs lag two edges
    // saturating age counter
    always @(posedge sys_clk or posedge rst) begin
        if (rst) age <= 2'h0;
        else if (age != 2'h3) age <= age + 2'h1;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_frame_answer: assert property (
        sample_valid && link_active && mode_supported |=> frame_valid)
        else $error("taken samples gave no frame");
    a_frame_cause: assert property (
        frame_valid |-> $past(sample_valid && link_active))
        else $error("frame without taken samples");
    a_lane_ids: assert property (lane_identifier == 24'hfac688)
        else $error("lane ids wrong");
    a_power_map: assert property (age == 2'h3 |-> lane_power_down == pd_exp)
        else $error("lane power map wrong");
    a_tail_zero: assert property (
        frame_valid && frame_octets == 4'h8 |->
            lane_frames[19:0] == 20'h0 && lane_frames[579:560] == 20'h0)
        else $error("tail bits not zero");
    a_pad_zero: assert property (
        frame_valid && frame_octets == 4'h5 |-> !lane_frames[70] && lane_frames[39:0] == 40'h0)
        else $error("pad bits not zero");
    a_narrow_lane: assert property (
        frame_valid && frame_octets == 4'h1 |-> lane_frames[71:0] == 72'h0)
        else $error("octet frame has extra bits");
    a_down_clear: assert property (
        lane_power_down[7] && $past(lane_power_down[7]) |-> lane_frames[639:560] == 80'h0)
        else $error("powered down lane not clear");
    a_config_hold: assert property (
        link_active && $past(link_active) && $past(link_active, 2) |->
            $stable(lane_device_id) && $stable(frame_octets))
        else $error("config moved while link up");
endmodule // slm_chk
bind slm_sample_mapper slm_chk #(.DID_W(DID_W), .NUM_CH(NUM_CH)) chk (.sys_clk, .rst,
    .link_active, .sample_valid, .lane_frames, .lane_power_down, .lane_identifier,
    .lane_device_id, .frame_valid, .frame_octets, .mode_supported);

// *** testbench/slm_rx_model.sv ***
`timescale 1ns/1ps
// receiver side: rebuilds channel a from the lane 0/1 pair
module slm_rx_model (
    input wire         sys_clk,
    input wire         frame_valid,
    input wire [639:0] lane_frames,
    output reg [89:0]  rx_chan_a
);
    integer k;
    // even samples sit on lane 0, odd on lane 1, msb first per slot
    always @(posedge sys_clk) begin
        if (frame_valid) begin
            for (k = 0; k < 10; k = k + 1) begin
                rx_chan_a[9*k +: 9] <= lane_frames[80*(k%2) + 79 - 12*(k/2) -: 9];
            end
        end
    end
endmodule // slm_rx_model

// *** testbench/slm_sample_mapper_test.sv ***
`timescale 1ns/1ps
module slm_sample_mapper_test;
    reg          sys_clk, rst, link_active, sample_valid;
    reg  [3:0]   link_mode_select;
    reg  [7:0]   device_identifier;
    reg  [89:0]  smp [0:3];
    reg  [15:0]  rows [0:5]; // mode, octets, power-down mask
    reg  [639:0] exp;
    wire [639:0] lane_frames, frames_one;
    wire [7:0]   lane_power_down, pd_one, lane_device_id;
    wire [23:0]  lane_identifier;
    wire [3:0]   frame_octets;
    wire [89:0]  rx_chan_a;
    wire         frame_valid, mode_supported;
    integer      n_fail, compares, r, g, k;
    slm_sample_mapper uut (.sys_clk, .rst, .link_active, .link_mode_select, .device_identifier,
        .sample_valid, .samp_a(smp[0]), .samp_b(smp[1]), .samp_c(smp[2]), .samp_d(smp[3]),
        .lane_frames, .lane_power_down, .lane_identifier, .lane_device_id, .frame_valid,
        .frame_octets, .mode_supported);
    // one-channel variant shares the stimulus
    slm_sample_mapper #(.NUM_CH(1)) uut1 (.sys_clk, .rst, .link_active, .link_mode_select,
        .device_identifier, .sample_valid, .samp_a(smp[0]), .samp_b(smp[1]), .samp_c(smp[2]),
        .samp_d(smp[3]), .lane_frames(frames_one), .lane_power_down(pd_one),
        .lane_identifier(), .lane_device_id(), .frame_valid(), .frame_octets(),
        .mode_supported());
    slm_rx_model rx (.sys_clk, .frame_valid, .lane_frames, .rx_chan_a);
    // expected frame of lane g for mode m on the four-channel variant
    function [79:0] exp_lane(input [3:0] m, input integer g);
        reg [47:0] p;
        integer    i;
        begin
            exp_lane = 80'h0;
            p = {smp[g/3*2][8:0], 3'h0, smp[g/3*2][17:9], 3'h0,
                 smp[g/3*2+1][8:0], 3'h0, smp[g/3*2+1][17:9], 3'h0};
            case (m)
                4'h0: for (i = 0; i < 5; i = i + 1)
                    exp_lane[79-12*i -: 12] = {smp[g/2][9*(g%2+2*i) +: 9], 3'h0};
                4'h1: if (g < 6) exp_lane[79:64] = p[47-16*(g%3) -: 16];
                4'h2: if (g < 4) exp_lane[79:72] = smp[g][8:1];
                4'h3: if (g < 4) for (i = 0; i < 4; i = i + 1)
                    exp_lane[79-10*i -: 10] = {smp[g][9*i +: 9], 1'b0};
                default: ;
            endcase
        end
    endfunction
    task chk(input [639:0] e, input [639:0] s, input string nm);
        compares = compares + 1;
        if (s !== e) begin
            $display("BAD %0s exp %h got %h", nm, e, s);
            n_fail = n_fail + 1;
        end
    endtask
    task end_of_test;
        if (n_fail == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // config only taken with the link down
    task cfg(input [3:0] m);
        link_active = 0;
        link_mode_select = m;
        device_identifier = {m, ~m};
        repeat (4) @(negedge sys_clk);
        link_active = 1;
        @(negedge sys_clk);
    endtask
    // one-cycle sample strobe; frame_valid is up at the following low phase
    task shot;
        sample_valid = 1;
        @(negedge sys_clk);
        sample_valid = 0;
    endtask
    initial begin
        sys_clk = 0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial begin
        n_fail = 0; compares = 0; rst = 1; link_active = 0; sample_valid = 0;
        link_mode_select = 4'h0; device_identifier = 8'h00;
        rows[0] = 16'h0800; rows[1] = 16'h12c0; rows[2] = 16'h21f0;
        rows[3] = 16'h35f0; rows[4] = 16'h50ff; rows[5] = 16'hf0ff;
        for (r = 0; r < 4; r = r + 1)
            for (k = 0; k < 10; k = k + 1) smp[r][9*k +: 9] = 9'h0a5 + r * 97 + k * 43;
        repeat (12) @(negedge sys_clk);
        rst = 0;
        for (r = 0; r < 6; r = r + 1) begin
            cfg(rows[r][15:12]);
            chk(rows[r][11:8], frame_octets, "octets");
            chk(rows[r][7:0], lane_power_down, "power down");
            chk(rows[r][11:8] != 4'h0, mode_supported, "supported");
            chk({rows[r][15:12], ~rows[r][15:12]}, lane_device_id, "device id");
            shot;
            chk(rows[r][11:8] != 4'h0, frame_valid, "frame valid");
            for (g = 0; g < 8; g = g + 1) exp[80*g +: 80] = exp_lane(rows[r][15:12], g);
            chk(exp, lane_frames, "frames");
            if (r == 1) chk(8'h00, frames_one[151:144], "single octet");
            if (r == 1) chk(8'hfc, pd_one, "single lanes");
            @(negedge sys_clk);
            chk(1'b0, frame_valid, "valid drop");
            if (r == 0) chk(smp[0], rx_chan_a, "rx chan a");
        end
        // mode change with link up is ignored, strobe refused in mode 15
        link_mode_select = 4'h0;
        repeat (3) @(negedge sys_clk);
        chk(4'h0, frame_octets, "frozen mode");
        shot;
        chk(1'b0, frame_valid, "refused mode");
        // strobe with link down is ignored
        link_active = 0;
        link_mode_select = 4'h3;
        repeat (3) @(negedge sys_clk);
        shot;
        chk(1'b0, frame_valid, "link down");
        link_active = 1;
        @(negedge sys_clk);
        // back-to-back strobes, second one carries new samples
        sample_valid = 1;
        @(negedge sys_clk);
        chk(1'b1, frame_valid, "first");
        smp[0] = ~smp[0];
        @(negedge sys_clk);
        sample_valid = 0;
        chk(1'b1, frame_valid, "second");
        chk(exp_lane(4'h3, 0), lane_frames[79:0], "lane0 new");
        // reset in mid-run clears lanes and powers them down
        rst = 1;
        @(negedge sys_clk);
        chk(8'hff, lane_power_down, "rst power");
        chk(640'h0, lane_frames, "rst frames");
        rst = 0;
        // link stays up across the release, so the reset mode 0 is kept
        @(negedge sys_clk);
        chk(8'h00, lane_power_down, "rst mode lanes");
        chk(4'h8, frame_octets, "rst mode octets");
        end_of_test;
    end
endmodule // slm_sample_mapper_test
